// *** verilog/sfpr_params.svh ***
// sfpr_params.svh: offsets, field positions, reset values and counts
// assumes inclusion by the controller package users only
`ifndef SFPR_PARAMS_SVH
`define SFPR_PARAMS_SVH

// ----------------------------------------------------------------
// device register map
// ----------------------------------------------------------------
`define SFPR_DEV_WORDCNT_OFS 32'h0000058C
`define SFPR_DEV_INTL_OFS    32'h00000590
`define SFPR_DEV_WHOLE_OFS   32'h00000594
`define SFPR_DEV_FRAC_OFS    32'h00000598
`define SFPR_DEV_WAIT_OFS    32'h0000059C

// ----------------------------------------------------------------
// controller register map
// ----------------------------------------------------------------
`define SFPR_CTRL_OFS   8'h00
`define SFPR_PIX_OFS    8'h04
`define SFPR_BW_OFS     8'h08
`define SFPR_UNIT_OFS   8'h0C
`define SFPR_STAT_OFS   8'h10
`define SFPR_LANE_OFS   8'h14
`define SFPR_RES_OFS    8'h18

// ----------------------------------------------------------------
// fields and codes
// ----------------------------------------------------------------
`define SFPR_CTRL_GO    0
`define SFPR_CTRL_INTL  1
`define SFPR_CTRL_LANE  2
`define SFPR_CTRL_FMT   4
`define SFPR_PIX_BPP    16
`define SFPR_BW_VIDEO   16
`define SFPR_LANES_1    2'h0
`define SFPR_LANES_2    2'h1
`define SFPR_LANES_4    2'h2
`define SFPR_FMT_FULL   2'h0
`define SFPR_FMT_HALF   2'h1
`define SFPR_FMT_LUMA   2'h2

// ----------------------------------------------------------------
// reset values and counts
// ----------------------------------------------------------------
`define SFPR_UNIT_RST    7'h40
`define SFPR_WAIT_SMALL  8'h40
`define SFPR_WHOLE_LIMIT 8'h04
`define SFPR_FRAC_SCALE  26'h00003E8
`define SFPR_WORD_ROUND  23'h00000F
`define SFPR_DIV_LAST    6'h1F
`define SFPR_LUMA_DIV    16'h0003

`endif

// *** verilog/sfpr_pkg.sv ***
// sfpr_pkg.sv: bus carriers and controller states
// assumes nothing beyond a SystemVerilog compiler
package sfpr_pkg;

  // ----------------------------------------------------------------
  // bus carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } sfpr_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } sfpr_apb_rsp_t;

  // ----------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_DIV_WHOLE,
    ST_DIV_FRAC,
    ST_DIV_WAIT,
    ST_SETUP,
    ST_ACCESS
  } sfpr_state_t;

endpackage

// *** verilog/sfpr_host.sv ***
// sfpr_host.sv: controller that derives and writes stream framing parameters
// assumes one clock shared with the device register port, apb on both sides
//
// Our own choice: the APB slave port.
`timescale 1ns/10ps
`default_nettype none
`include "sfpr_params.svh"

module sfpr_host
  import sfpr_pkg::*;
(
  // clock and reset
  input  wire logic          clk,
  input  wire logic          rst_n,
  // software register port
  input  wire sfpr_apb_req_t sw_req,
  output var  sfpr_apb_rsp_t sw_rsp,
  // device register port
  output var  sfpr_apb_req_t dev_req,
  input  wire sfpr_apb_rsp_t dev_rsp
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  sfpr_state_t state;
  logic        ctrl_intl;
  logic [1:0]  ctrl_lanes;
  logic [1:0]  ctrl_fmt;
  logic [15:0] active_pixels_per_line;
  logic [5:0]  bpp;
  logic [15:0] link_bandwidth;
  logic [15:0] video_bandwidth;
  logic [6:0]  unit_size;
  logic        busy;
  logic        done;
  logic        div_err;
  logic        dev_err;
  logic [31:0] per_lane;
  logic [31:0] whole_q;
  logic [7:0]  whole;
  logic [15:0] rem;
  logic [9:0]  frac;
  logic [7:0]  wait_cyc;
  logic [31:0] div_q;
  logic [16:0] div_r;
  logic [15:0] div_d;
  logic [5:0]  div_cnt;
  logic [2:0]  wr_idx;
  logic        m_psel;
  logic        m_penable;
  logic [31:0] m_paddr;
  logic [31:0] m_pwdata;
  logic [31:0] sw_rdata;
  logic        sw_err;

  // ----------------------------------------------------------------
  // software port decode
  // ----------------------------------------------------------------
  wire [7:0]  sw_ofs     = sw_req.paddr[7:0];
  wire        hit_ctrl   = sw_ofs == `SFPR_CTRL_OFS;
  wire        hit_pix    = sw_ofs == `SFPR_PIX_OFS;
  wire        hit_bw     = sw_ofs == `SFPR_BW_OFS;
  wire        hit_unit   = sw_ofs == `SFPR_UNIT_OFS;
  wire        hit_stat   = sw_ofs == `SFPR_STAT_OFS;
  wire        hit_lane   = sw_ofs == `SFPR_LANE_OFS;
  wire        hit_res    = sw_ofs == `SFPR_RES_OFS;
  wire        sw_hit     = hit_ctrl | hit_pix | hit_bw | hit_unit | hit_stat | hit_lane
                           | hit_res;
  wire        sw_setup   = sw_req.psel & ~sw_req.penable;
  wire        sw_wr      = sw_req.psel & sw_req.penable & sw_req.pwrite & ~busy;
  wire        go         = sw_wr & hit_ctrl & sw_req.pwdata[`SFPR_CTRL_GO];
  wire [31:0] sw_rd_mux  =
      hit_ctrl ? {26'h0, ctrl_fmt, ctrl_lanes, ctrl_intl, busy} :
      hit_pix  ? {10'h0, bpp, active_pixels_per_line} :
      hit_bw   ? {video_bandwidth, link_bandwidth} :
      hit_unit ? {25'h0, unit_size} :
      hit_stat ? {28'h0, dev_err, div_err, done, busy} :
      hit_lane ? per_lane :
      hit_res  ? {6'h0, wait_cyc, frac, whole} : 32'h0;

  assign sw_rsp = '{pready: 1'b1, pslverr: sw_err, prdata: sw_rdata};

  // ----------------------------------------------------------------
  // word count per lane
  // ----------------------------------------------------------------
  wire [21:0] pix_bits   = active_pixels_per_line * bpp;
  wire [22:0] pix_round  = {1'b0, pix_bits} + `SFPR_WORD_ROUND;
  wire [18:0] words      = pix_round[22:4];
  wire [31:0] words_ext  = {13'h0, words};
  wire [31:0] lane_cnt   =
      (ctrl_lanes == `SFPR_LANES_1) ? words_ext - 32'h1 :
      (ctrl_lanes == `SFPR_LANES_2) ? words_ext + {31'h0, words[0]} - 32'h2 :
      words_ext + {30'h0, words[1:0]} - 32'h4;

  // ----------------------------------------------------------------
  // shared serial divider
  // ----------------------------------------------------------------
  wire [16:0] div_shift  = {div_r[15:0], div_q[31]};
  wire        div_fit    = div_shift >= {1'b0, div_d};
  wire [16:0] next_div_r = div_fit ? div_shift - {1'b0, div_d} : div_shift;
  wire [31:0] next_div_q = {div_q[30:0], div_fit};
  wire        div_last   = div_cnt == `SFPR_DIV_LAST;
  wire [22:0] bw_unit    = link_bandwidth * unit_size;
  wire [25:0] rem_scaled = {10'h0, rem} * `SFPR_FRAC_SCALE;
  wire [25:0] frac_load  = {10'h0, next_div_r[15:0]} * `SFPR_FRAC_SCALE;
  wire [7:0]  wait_diff  = {1'b0, unit_size} - whole;
  wire        wait_small = whole <= `SFPR_WHOLE_LIMIT;
  wire [7:0]  wait_fmt   =
      wait_small                   ? `SFPR_WAIT_SMALL :
      (ctrl_fmt == `SFPR_FMT_HALF) ? {1'b0, wait_diff[7:1]} :
      wait_diff;

  // ----------------------------------------------------------------
  // device write selection
  // ----------------------------------------------------------------
  wire [2:0]  nxt_idx    = (state == ST_ACCESS) ? wr_idx + 3'h1 : 3'h0;
  wire [31:0] nxt_addr   =
      (nxt_idx == 3'h0) ? `SFPR_DEV_WORDCNT_OFS :
      (nxt_idx == 3'h1) ? `SFPR_DEV_INTL_OFS :
      (nxt_idx == 3'h2) ? `SFPR_DEV_WHOLE_OFS :
      (nxt_idx == 3'h3) ? `SFPR_DEV_FRAC_OFS : `SFPR_DEV_WAIT_OFS;
  wire [31:0] nxt_data   =
      (nxt_idx == 3'h0) ? per_lane :
      (nxt_idx == 3'h1) ? {31'h0, ctrl_intl} :
      (nxt_idx == 3'h2) ? {24'h0, whole} :
      (nxt_idx == 3'h3) ? {22'h0, frac} : {24'h0, wait_cyc};
  wire        wr_last    = wr_idx == 3'h4;

  assign dev_req = '{psel: m_psel, penable: m_penable, pwrite: 1'b1,
                     paddr: m_paddr, pwdata: m_pwdata};

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_intl  <= 1'b0;
      ctrl_lanes <= 2'h0;
      ctrl_fmt   <= 2'h0;
      active_pixels_per_line       <= 16'h0;
      bpp        <= 6'h0;
      link_bandwidth    <= 16'h0;
      video_bandwidth   <= 16'h0;
      unit_size  <= `SFPR_UNIT_RST;
      sw_rdata   <= 32'h0;
      sw_err     <= 1'b0;
    end else begin
      if (sw_setup) begin
        sw_rdata <= sw_rd_mux;
        sw_err   <= ~sw_hit;
      end
      if (sw_wr && hit_ctrl) begin
        ctrl_intl  <= sw_req.pwdata[`SFPR_CTRL_INTL];
        ctrl_lanes <= sw_req.pwdata[`SFPR_CTRL_LANE +: 2];
        ctrl_fmt   <= sw_req.pwdata[`SFPR_CTRL_FMT +: 2];
      end
      if (sw_wr && hit_pix) begin
        active_pixels_per_line <= sw_req.pwdata[15:0];
        bpp  <= sw_req.pwdata[`SFPR_PIX_BPP +: 6];
      end
      if (sw_wr && hit_bw) begin
        link_bandwidth  <= sw_req.pwdata[15:0];
        video_bandwidth <= sw_req.pwdata[`SFPR_BW_VIDEO +: 16];
      end
      if (sw_wr && hit_unit) begin
        unit_size <= {sw_req.pwdata[6:1], 1'b0};
      end
    end
  end

  // ----------------------------------------------------------------
  // sequencer: compute, then write the device
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state     <= ST_IDLE;
      busy      <= 1'b0;
      done      <= 1'b0;
      div_err   <= 1'b0;
      dev_err   <= 1'b0;
      per_lane  <= 32'h0;
      whole_q   <= 32'h0;
      whole     <= 8'h0;
      rem       <= 16'h0;
      frac      <= 10'h0;
      wait_cyc  <= 8'h0;
      div_q     <= 32'h0;
      div_r     <= 17'h0;
      div_d     <= 16'h0;
      div_cnt   <= 6'h0;
      wr_idx    <= 3'h0;
      m_psel    <= 1'b0;
      m_penable <= 1'b0;
      m_paddr   <= 32'h0;
      m_pwdata  <= 32'h0;
    end else begin
      if (state != ST_IDLE) begin
        div_q   <= next_div_q;
        div_r   <= next_div_r;
        div_cnt <= div_cnt + 6'h1;
      end
      unique case (state)
        ST_IDLE: begin
          if (go) begin
            done     <= 1'b0;
            dev_err  <= 1'b0;
            div_err  <= video_bandwidth == 16'h0;
            busy     <= video_bandwidth != 16'h0;
            div_q    <= {9'h0, bw_unit};
            div_r    <= 17'h0;
            div_d    <= video_bandwidth;
            div_cnt  <= 6'h0;
            state    <= (video_bandwidth == 16'h0) ? ST_IDLE : ST_DIV_WHOLE;
          end
        end
        ST_DIV_WHOLE: begin
          if (div_last) begin
            whole_q <= next_div_q;
            whole   <= next_div_q[7:0];
            rem     <= next_div_r[15:0];
            per_lane <= lane_cnt;
            div_q   <= {6'h0, frac_load};
            div_r   <= 17'h0;
            div_cnt <= 6'h0;
            state   <= ST_DIV_FRAC;
          end
        end
        ST_DIV_FRAC: begin
          if (div_last) begin
            frac <= next_div_q[9:0];
            if (!wait_small && ctrl_fmt == `SFPR_FMT_LUMA) begin
              div_q   <= {24'h0, wait_diff};
              div_r   <= 17'h0;
              div_d   <= `SFPR_LUMA_DIV;
              div_cnt <= 6'h0;
              state   <= ST_DIV_WAIT;
            end else begin
              wait_cyc <= wait_fmt;
              state    <= ST_SETUP;
              m_psel   <= 1'b1;
              m_paddr  <= nxt_addr;
              m_pwdata <= nxt_data;
            end
          end
        end
        ST_DIV_WAIT: begin
          if (div_last) begin
            wait_cyc <= next_div_q[7:0];
            state    <= ST_SETUP;
            m_psel   <= 1'b1;
            m_paddr  <= nxt_addr;
            m_pwdata <= nxt_data;
          end
        end
        ST_SETUP: begin
          m_penable <= 1'b1;
          state     <= ST_ACCESS;
        end
        ST_ACCESS: begin
          if (dev_rsp.pready) begin
            m_penable <= 1'b0;
            dev_err   <= dev_err | dev_rsp.pslverr;
            if (wr_last) begin
              m_psel <= 1'b0;
              busy   <= 1'b0;
              done   <= 1'b1;
              wr_idx <= 3'h0;
              state  <= ST_IDLE;
            end else begin
              wr_idx   <= nxt_idx;
              m_paddr  <= nxt_addr;
              m_pwdata <= nxt_data;
              state    <= ST_SETUP;
            end
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  wire dev_wr    = m_psel & m_penable;
  wire lane_load = (state == ST_DIV_WHOLE) & div_last;

  words_round_a: assert property (
    ({words, 4'h0} >= {1'b0, pix_bits}) && ({words, 4'h0} < {1'b0, pix_bits} + 23'h10))
    else $error("word count not rounded up");
  lane_one_a: assert property (
    (lane_load && ctrl_lanes == `SFPR_LANES_1) |=> per_lane == $past(words_ext) - 32'h1)
    else $error("one lane count wrong");
  lane_two_a: assert property (
    (lane_load && ctrl_lanes == `SFPR_LANES_2)
      |=> per_lane + 32'h2 == $past(words_ext) + {31'h0, $past(words[0])})
    else $error("two lane count wrong");
  lane_four_a: assert property (
    (lane_load && ctrl_lanes == `SFPR_LANES_4)
      |=> per_lane + 32'h4 == $past(words_ext) + {30'h0, $past(words[1:0])})
    else $error("four lane count wrong");
  intl_write_a: assert property (
    (dev_wr && m_paddr == `SFPR_DEV_INTL_OFS) |-> m_pwdata == {31'h0, ctrl_intl})
    else $error("interlace value wrong");
  whole_div_a: assert property (
    (state == ST_DIV_WHOLE && div_last)
      |=> ({16'h0, whole_q} * {32'h0, video_bandwidth} + {32'h0, rem} == {25'h0, bw_unit})
          && (rem < video_bandwidth))
    else $error("whole quotient wrong");
  frac_div_a: assert property (
    (state == ST_DIV_FRAC && div_last)
      |=> ({22'h0, frac} * {16'h0, video_bandwidth} <= {6'h0, rem_scaled})
          && ({22'h0, frac} * {16'h0, video_bandwidth} + {16'h0, video_bandwidth} > {6'h0, rem_scaled}))
    else $error("fraction quotient wrong");
  wait_small_a: assert property (
    (dev_wr && m_paddr == `SFPR_DEV_WAIT_OFS && wait_small)
      |-> m_pwdata == {24'h0, `SFPR_WAIT_SMALL})
    else $error("small whole wait wrong");
  wait_full_a: assert property (
    (dev_wr && m_paddr == `SFPR_DEV_WAIT_OFS && !wait_small && ctrl_fmt == `SFPR_FMT_FULL)
      |-> m_pwdata == {24'h0, wait_diff})
    else $error("full chroma wait wrong");
  wait_half_a: assert property (
    (dev_wr && m_paddr == `SFPR_DEV_WAIT_OFS && !wait_small && ctrl_fmt == `SFPR_FMT_HALF)
      |-> m_pwdata == {25'h0, wait_diff[7:1]})
    else $error("half chroma wait wrong");
  wait_luma_a: assert property (
    (dev_wr && m_paddr == `SFPR_DEV_WAIT_OFS && !wait_small && ctrl_fmt == `SFPR_FMT_LUMA)
      |-> ({wait_cyc, 1'b0} + {1'b0, wait_cyc} <= {1'b0, wait_diff})
          && ({wait_cyc, 1'b0} + {1'b0, wait_cyc} + 9'h3 > {1'b0, wait_diff}))
    else $error("luma wait wrong");
  unit_even_a: assert property (unit_size[0] == 1'b0)
    else $error("unit size odd");
  req_hold_a: assert property (
    (m_psel && m_penable && !dev_rsp.pready) |=> $stable(dev_req) && m_penable)
    else $error("device request moved while waiting");

endmodule

`default_nettype wire

// *** test/sfpr_dev_model.sv ***
// sfpr_dev_model.sv: behavioural device holding the five stream framing registers
// assumes an apb master on req, one clock, async active-low reset
`timescale 1ns/10ps
`default_nettype none
`include "sfpr_params.svh"
module sfpr_dev_model
  import sfpr_pkg::*;
(
  // clock and reset
  input  wire logic          clk,
  input  wire logic          rst_n,
  // register port
  input  wire sfpr_apb_req_t req,
  output var  sfpr_apb_rsp_t rsp,
  // test controls
  input  wire logic [3:0]    stall,
  input  wire logic          err_en,
  // stored parameters, write count and order flag
  output var  logic [31:0]   word_count,
  output var  logic [31:0]   interlace,
  output var  logic [31:0]   whole,
  output var  logic [31:0]   frac,
  output var  logic [31:0]   line_wait,
  output var  logic [7:0]    writes,
  output var  logic          order_bad
);
  logic [3:0]  cnt;
  logic [2:0]  idx;
  logic        tog;
  wire  logic  access = req.psel & req.penable;
  wire  logic  done = access & (cnt >= stall);
  wire  logic [31:0] exp_addr = 32'h0000058C + {27'h0, idx, 2'b00};
  // ----------------------------------------------------------------
  // answer: slow by stall cycles, released data keeps changing
  // ----------------------------------------------------------------
  assign rsp = '{pready: done, pslverr: done & err_en, prdata: {16{tog, ~tog}}};
  // ----------------------------------------------------------------
  // register store
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt        <= 4'h0;
      idx        <= 3'h0;
      tog        <= 1'b0;
      word_count <= 32'h0;
      interlace  <= 32'h0;
      whole      <= 32'h0;
      frac       <= 32'h0;
      line_wait  <= 32'h0;
      writes     <= 8'h0;
      order_bad  <= 1'b0;
    end else begin
      tog <= ~tog;
      cnt <= (access && !done) ? cnt + 4'h1 : 4'h0;
      if (done) begin
        writes <= writes + 8'h1;
        idx    <= (idx == 3'h4) ? 3'h0 : idx + 3'h1;
        if (req.paddr != exp_addr || !req.pwrite) begin
          order_bad <= 1'b1;
        end
        case (req.paddr)
          `SFPR_DEV_WORDCNT_OFS: word_count <= req.pwdata;
          `SFPR_DEV_INTL_OFS:    interlace  <= req.pwdata;
          `SFPR_DEV_WHOLE_OFS:   whole      <= req.pwdata;
          `SFPR_DEV_FRAC_OFS:    frac       <= req.pwdata;
          `SFPR_DEV_WAIT_OFS:    line_wait  <= req.pwdata;
          default: ;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// *** test/tb.sv ***
// tb.sv: self-checking bench for the framing parameter controller
// assumes sfpr_dev_model stands behind the controller's device port
`timescale 1ns/10ps
`default_nettype none
`include "sfpr_params.svh"
module tb
  import sfpr_pkg::*;
;
  logic          clk;
  logic          rst_n;
  sfpr_apb_req_t sw_req;
  sfpr_apb_rsp_t sw_rsp;
  sfpr_apb_req_t dev_req;
  sfpr_apb_rsp_t dev_rsp;
  logic [3:0]    stall;
  logic          err_en;
  logic [31:0]   dv_wc, dv_il, dv_wh, dv_fr, dv_wt;
  logic [7:0]    dv_writes;
  logic          dv_bad;
  logic [31:0]   rd;
  logic          er;
  int            fail_count;
  int            samples_checked;
  // ----------------------------------------------------------------
  // design and device
  // ----------------------------------------------------------------
  sfpr_host sfpr_host_i (.clk(clk), .rst_n(rst_n), .sw_req(sw_req), .sw_rsp(sw_rsp),
    .dev_req(dev_req), .dev_rsp(dev_rsp));
  sfpr_dev_model sfpr_dev_model_i (.clk(clk), .rst_n(rst_n), .req(dev_req), .rsp(dev_rsp),
    .stall(stall), .err_en(err_en), .word_count(dv_wc), .interlace(dv_il), .whole(dv_wh),
    .frac(dv_fr), .line_wait(dv_wt), .writes(dv_writes), .order_bad(dv_bad));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("mismatches=%0d checks=%0d", fail_count, samples_checked);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    sw_req.psel    <= 1'b1;
    sw_req.penable <= 1'b0;
    sw_req.pwrite  <= w;
    sw_req.paddr   <= {24'h0, a};
    sw_req.pwdata  <= d;
    @(posedge clk);
    sw_req.penable <= 1'b1;
    @(posedge clk);
    while (sw_rsp.pready !== 1'b1) @(posedge clk);
    rd = sw_rsp.prdata;
    er = sw_rsp.pslverr;
    sw_req.psel    <= 1'b0;
    sw_req.penable <= 1'b0;
  endtask
  task automatic go_wait(input logic [31:0] ctrl);
    int n;
    n = 0;
    apb(1'b1, `SFPR_CTRL_OFS, ctrl);
    apb(1'b1, `SFPR_UNIT_OFS, 32'h20);
    rd = 32'h1;
    while (rd[0] !== 1'b0 && n < 500) begin
      apb(1'b0, `SFPR_STAT_OFS, 32'h0);
      n++;
    end
  endtask
  task automatic run_case(input logic [15:0] active_pixels_per_line, input logic [5:0] bpp,
      input logic [1:0] ln, input logic [1:0] fm, input logic il, input logic [15:0] lk,
      input logic [15:0] vd, input logic [6:0] un, input logic [3:0] st, input logic ev);
    logic [31:0] w, wc, num, wh, fr, wt, diff;
    logic [6:0]  u;
    logic [7:0]  n0;
    u    = un & 7'h7E;
    w    = ({16'h0, active_pixels_per_line} * {26'h0, bpp} + 32'hF) >> 4;
    wc   = (ln == 2'h0) ? w - 1 : (ln == 2'h1) ? w + w % 2 - 2 : w + w % 4 - 4;
    num  = {16'h0, lk} * {25'h0, u};
    wh   = (num / {16'h0, vd}) & 32'hFF;
    fr   = (num % {16'h0, vd}) * 32'd1000 / {16'h0, vd};
    diff = ({25'h0, u} - wh) & 32'hFF;
    wt   = (wh <= 4) ? 32'd64 : (fm == `SFPR_FMT_HALF) ? diff >> 1 :
           (fm == `SFPR_FMT_LUMA) ? diff / 3 : diff;
    stall  <= st;
    err_en <= ev;
    n0 = dv_writes;
    apb(1'b1, `SFPR_PIX_OFS, {10'h0, bpp, active_pixels_per_line});
    apb(1'b1, `SFPR_BW_OFS, {vd, lk});
    apb(1'b1, `SFPR_UNIT_OFS, {25'h0, un});
    apb(1'b0, `SFPR_PIX_OFS, 32'h0);
    check(rd, {10'h0, bpp, active_pixels_per_line});
    go_wait({26'h0, fm, ln, il, 1'b1});
    check(rd, {28'h0, ev, 3'b010});
    check(dv_wc, wc);
    check(dv_il, {31'h0, il});
    check(dv_wh, wh);
    check(dv_fr, fr);
    check(dv_wt, wt);
    check({24'h0, dv_writes - n0}, 32'h5);
    check({31'h0, dv_bad}, 32'h0);
    apb(1'b0, `SFPR_LANE_OFS, 32'h0);
    check(rd, wc);
    apb(1'b0, `SFPR_RES_OFS, 32'h0);
    check(rd, {6'h0, wt[7:0], fr[9:0], wh[7:0]});
    apb(1'b0, `SFPR_UNIT_OFS, 32'h0);
    check(rd, {25'h0, u});
  endtask
  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    sw_req = '0;
    stall = 4'h0;
    err_en = 1'b0;
    rst_n = 1'b0;
    rd = 32'h0;
    er = 1'b0;
    fail_count = 0;
    samples_checked = 0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, `SFPR_UNIT_OFS, 32'h0);
    check(rd, 32'h40);
    apb(1'b0, `SFPR_STAT_OFS, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, 8'h1C, 32'h0);
    check({31'h0, er}, 32'h1);
    run_case(16'd1920, 6'd24, 2'h0, `SFPR_FMT_FULL, 1'b1, 16'd1000, 16'd1500, 7'h40, 4'h0, 1'b0);
    run_case(16'd7, 6'd18, 2'h1, `SFPR_FMT_HALF, 1'b0, 16'd1000, 16'd1500, 7'h33, 4'h3, 1'b0);
    run_case(16'd5, 6'd16, 2'h2, `SFPR_FMT_LUMA, 1'b1, 16'd100, 16'd1600, 7'h40, 4'h1, 1'b1);
    run_case(16'd9, 6'd16, 2'h1, `SFPR_FMT_LUMA, 1'b0, 16'd1000, 16'd1500, 7'h40, 4'h0, 1'b0);
    run_case(16'd3, 6'd30, 2'h2, 2'h3, 1'b0, 16'd1000, 16'd1500, 7'h3E, 4'h2, 1'b0);
    apb(1'b1, `SFPR_BW_OFS, 32'h000003E8);
    go_wait(32'h1);
    check({31'h0, rd[2]}, 32'h1);
    check({24'h0, dv_writes}, 32'd25);
    give_verdict();
  end
  initial begin
    #80000;
    fail_count++;
    give_verdict();
  end
endmodule
`default_nettype wire
